// *** include/isr_pkg.sv ***
package isr_pkg;
    // register map
    localparam logic [7:0] STATUS_OFFSET = 8'h25;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    // status bit positions
    localparam int POS_PIN_CHANGE = 7;
    localparam int POS_WATCHDOG = 6;
    localparam int POS_ADDR_MATCH = 5;
    localparam int POS_FLOW_CHAR = 4;
    localparam int POS_TIMER = 3;
    localparam int POS_BREAK = 2;
    localparam int POS_RX_LEVEL = 1;
    localparam int POS_TX_SPACE = 0;
    // command register: bit 5 is a don't-care for every command
    localparam logic [5:0] CMD_CARE = 6'h1f;
    localparam logic [5:0] CMD_RESET_ADDR_MATCH = 6'h1b;
    // mode fields
    localparam int RX_FILL_LSB = 2;
    localparam int TX_FILL_LSB = 4;
    // receiver idle watchdog limit in bit times
    localparam int WATCHDOG_BITS = 64;
    // queue depth
    localparam int QUEUE_DEPTH = 256;
endpackage

// *** hdl/idle_watchdog.sv ***
`timescale 1ns/1ns
module idle_watchdog
    import isr_pkg::*;
#(
    parameter int LIMIT = WATCHDOG_BITS
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // bit-time tick and restart
    input wire logic bit_tick,
    input wire logic restart,
    // one-cycle pulse when the idle count passes the limit
    output logic expired
);
    localparam int CW = $clog2(LIMIT + 2);
    localparam logic [CW-1:0] TRIP = CW'(LIMIT + 1);

    logic [CW-1:0] count_q; // bit times since last queue event
    logic expired_q; // registered timeout pulse

    // count saturates at the trip value so it fires only once per idle spell
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_q <= '0;
        end else if (ce) begin
            if (restart) begin
                count_q <= '0; // restart wins over a tick in the same cycle
            end else if (bit_tick && count_q != TRIP) begin
                count_q <= count_q + CW'(1);
            end
        end
    end

    // pulse on the tick that takes the count above the limit
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            expired_q <= 1'b0;
        end else if (ce) begin
            expired_q <= !restart && bit_tick && (count_q == TRIP - CW'(1));
        end
    end

    assign expired = expired_q;
endmodule // idle_watchdog

// *** hdl/uart_interrupt_status.sv ***
// Summary of operation
// RULE1: arbitration request when status and mask set
// RULE2: masked bits never touch interrupt request
// RULE3: config bit 0 selects raw or masked read
// RULE4: pin change sets bit 7, port read clears
// RULE5: watchdog over 64 bit times sets bit 6
// RULE6: queue reads or loads restart watchdog
// RULE7: queue reads clear bit 6
// RULE8: address match sets bit 5
// RULE9: reset address command clears bit 5
// RULE10: flow character received sets bit 4
// RULE11: flow status read clears bit 4
// RULE12: timer expiry or zero pass sets bit 3
// RULE13: stop timer command clears bit 3
// RULE14: break start or end sets bit 2
// RULE15: reset break command clears bit 2
// RULE16: bit 1 high while rx level meets threshold
// RULE17: bit 0 high while tx level below trigger
// RULE18: status read itself clears nothing
`timescale 1ns/1ns
module uart_interrupt_status
    import isr_pkg::*;
#(
    parameter int DEPTH = QUEUE_DEPTH,
    parameter logic [5:0] CMD_STOP_TIMER = 6'h0c, // arbitrary default
    parameter logic [5:0] CMD_RESET_BREAK = 6'h05 // arbitrary default
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // host register read port
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // host side effects from neighbouring registers
    input wire logic input_port_value_rd,
    input wire logic receive_queue_rd,
    input wire logic global_receive_queue_rd,
    input wire logic flow_char_status_rd,
    input wire logic command_register_wr,
    input wire logic [5:0] command_register_code,
    // configuration
    input wire logic [7:0] interrupt_mask,
    input wire logic global_chip_config0,
    input wire logic [7:0] mode_reg_zero,
    input wire logic [7:0] mode_reg_two,
    // event sources
    input wire logic input_pin_one,
    input wire logic input_pin_zero,
    input wire logic bit_tick,
    input wire logic rx_char_loaded,
    input wire logic addr_match_event,
    input wire logic flow_char_event,
    input wire logic timer_event,
    input wire logic break_change_event,
    input wire logic [$clog2(DEPTH+1)-1:0] rx_level,
    input wire logic [$clog2(DEPTH+1)-1:0] tx_level,
    // interrupt outputs
    output logic [7:0] arb_request,
    output logic interrupt_request_n
);
    localparam int LW = $clog2(DEPTH + 1);
    localparam logic [LW-1:0] LVL_ONE = LW'(1);
    localparam logic [LW-1:0] LVL_HALF = LW'(DEPTH / 2);
    localparam logic [LW-1:0] LVL_3Q = LW'((DEPTH * 3) / 4);
    localparam logic [LW-1:0] LVL_FULL = LW'(DEPTH);
    localparam logic [LW-1:0] LVL_1Q = LW'(DEPTH / 4);

    logic [7:0] status_q; // interrupt status bits
    logic [7:0] set_ev; // per-bit set events
    logic [7:0] clr_ev; // per-bit clear events
    logic [1:0] pins_q; // last sampled input pins
    logic pins_valid_q; // pins_q holds a real sample
    logic wd_expired; // watchdog timeout pulse
    logic wd_restart; // receive-queue event
    logic rx_queue_read; // either receive queue read
    logic [5:0] cmd_care; // command code, don't-care bit dropped
    logic [LW-1:0] rx_thresh; // selected receive threshold
    logic [LW-1:0] tx_trigger; // selected transmit trigger
    logic rx_level_hit; // receive level at or above threshold
    logic tx_space_hit; // transmit level below trigger
    logic [7:0] armed; // status gated by mask
    logic [7:0] read_view; // value a status read returns
    logic [7:0] rdata_q; // read data register
    logic rvalid_q; // read data valid pulse
    logic irq_n_q; // registered interrupt request

    assign rx_queue_read = receive_queue_rd | global_receive_queue_rd;
    assign wd_restart = rx_queue_read | rx_char_loaded; // [RULE6]
    assign cmd_care = command_register_code & CMD_CARE;

    // receiver idle watchdog
    idle_watchdog #(
        .LIMIT(WATCHDOG_BITS)
    ) u_watchdog (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .bit_tick(bit_tick),
        .restart(wd_restart),
        .expired(wd_expired) // [RULE5]
    );

    // pin history; the first sample after reset only primes it,
    // so a pin sitting high out of reset is not taken as a change
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pins_q <= 2'h0;
            pins_valid_q <= 1'b0;
        end else if (ce) begin
            pins_q <= {input_pin_one, input_pin_zero};
            pins_valid_q <= 1'b1;
        end
    end

    // set conditions of the sticky bits
    always_comb begin
        set_ev = 8'h00;
        set_ev[POS_PIN_CHANGE] = pins_valid_q &&
            (pins_q != {input_pin_one, input_pin_zero}); // [RULE4]
        set_ev[POS_WATCHDOG] = wd_expired; // [RULE5]
        set_ev[POS_ADDR_MATCH] = addr_match_event; // [RULE8]
        set_ev[POS_FLOW_CHAR] = flow_char_event; // [RULE10]
        set_ev[POS_TIMER] = timer_event; // [RULE12]
        set_ev[POS_BREAK] = break_change_event; // [RULE14]
    end

    // clear side effects; a status read appears nowhere here
    always_comb begin
        clr_ev = 8'h00; // [RULE18]
        clr_ev[POS_PIN_CHANGE] = input_port_value_rd; // [RULE4]
        clr_ev[POS_WATCHDOG] = rx_queue_read; // [RULE7]
        clr_ev[POS_ADDR_MATCH] = command_register_wr &&
            (cmd_care == (CMD_RESET_ADDR_MATCH & CMD_CARE)); // [RULE9]
        clr_ev[POS_FLOW_CHAR] = flow_char_status_rd; // [RULE11]
        clr_ev[POS_TIMER] = command_register_wr &&
            (cmd_care == (CMD_STOP_TIMER & CMD_CARE)); // [RULE13]
        clr_ev[POS_BREAK] = command_register_wr &&
            (cmd_care == (CMD_RESET_BREAK & CMD_CARE)); // [RULE15]
    end

    // receive threshold select: ready, half, three quarters, full
    always_comb begin
        case (mode_reg_two[RX_FILL_LSB +: 2])
            2'h0: rx_thresh = LVL_ONE;
            2'h1: rx_thresh = LVL_HALF;
            2'h2: rx_thresh = LVL_3Q;
            2'h3: rx_thresh = LVL_FULL;
            default: rx_thresh = LVL_ONE;
        endcase
    end

    // transmit trigger select: default waits for a fully empty queue
    always_comb begin
        case (mode_reg_zero[TX_FILL_LSB +: 2])
            2'h0: tx_trigger = LVL_ONE;
            2'h1: tx_trigger = LVL_1Q;
            2'h2: tx_trigger = LVL_HALF;
            2'h3: tx_trigger = LVL_3Q;
            default: tx_trigger = LVL_ONE;
        endcase
    end

    // level bits; an empty receive queue never meets a threshold of one
    assign rx_level_hit = rx_level >= rx_thresh; // [RULE16]
    assign tx_space_hit = tx_level < tx_trigger; // [RULE17]

    // sticky bits, one per generated slice; set beats a same-cycle clear
    genvar gi;
    generate
        for (gi = POS_BREAK; gi <= POS_PIN_CHANGE; gi++) begin : g_sticky
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    status_q[gi] <= STATUS_RESET[gi];
                end else if (ce) begin
                    status_q[gi] <= set_ev[gi] | (status_q[gi] & ~clr_ev[gi]);
                end
            end
        end
    endgenerate

    // level-following bits, resampled every cycle in which ce is high
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status_q[POS_RX_LEVEL] <= STATUS_RESET[POS_RX_LEVEL];
            status_q[POS_TX_SPACE] <= STATUS_RESET[POS_TX_SPACE];
        end else if (ce) begin
            status_q[POS_RX_LEVEL] <= rx_level_hit; // [RULE16]
            status_q[POS_TX_SPACE] <= tx_space_hit; // [RULE17]
        end
    end

    // only bits that are both set and enabled reach arbitration
    assign armed = status_q & interrupt_mask; // [RULE1]
    assign arb_request = armed; // [RULE1]

    // request is built from armed bits only, so a zero mask bit has no say
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_n_q <= 1'b1;
        end else if (ce) begin
            irq_n_q <= ~(|armed); // [RULE2]
        end
    end
    assign interrupt_request_n = irq_n_q;

    // read view chosen by the global config bit
    assign read_view = global_chip_config0 ? armed : status_q; // [RULE3]

    // read port; unmapped addresses answer zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else if (ce) begin
            rvalid_q <= reg_rd;
            if (reg_rd) begin
                rdata_q <= (reg_addr == STATUS_OFFSET) ? read_view : 8'h00; // [RULE3]
            end
        end
    end
    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
endmodule // uart_interrupt_status

// *** test/isr_monitor.sv ***
`timescale 1ns/1ns
module isr_monitor
    import isr_pkg::*;
#(parameter logic [5:0] CMD_STOP_TIMER = 6'h0c) (
    // clock, reset, host side
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    input wire logic command_register_wr,
    input wire logic [5:0] command_register_code,
    input wire logic [7:0] interrupt_mask,
    input wire logic global_chip_config0,
    // events and outputs
    input wire logic timer_event,
    input wire logic addr_match_event,
    input wire logic [7:0] arb_request,
    input wire logic interrupt_request_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // bit 5 of a command is don't-care, so only the low five bits decode
    wire [4:0] op = command_register_code[4:0];
    property p_gate; (arb_request & ~interrupt_mask) == 8'h00; endproperty
    a_gate: assert property (p_gate) else $error("masked bit reached arbiter");
    property p_irq; ce |=> interrupt_request_n == ~|$past(arb_request); endproperty
    a_irq: assert property (p_irq) else $error("request does not follow armed bits");
    property p_quiet; (ce && arb_request == 8'h00) [*2] |-> interrupt_request_n; endproperty
    a_quiet: assert property (p_quiet) else $error("request with nothing armed");
    property p_read; ce && reg_rd && reg_addr == STATUS_OFFSET
        |=> (reg_rdata & $past(interrupt_mask)) == $past(arb_request); endproperty
    a_read: assert property (p_read) else $error("status read data wrong");
    // masked view: nothing disabled may show in the read data
    property p_mread; ce && reg_rd && reg_addr == STATUS_OFFSET && global_chip_config0
        |=> reg_rdata == $past(arb_request); endproperty
    a_mread: assert property (p_mread) else $error("masked read shows disabled bits");
    property p_tset; ce && timer_event |=> arb_request[3] || !interrupt_mask[3]; endproperty
    a_tset: assert property (p_tset) else $error("timer flag not set");
    property p_tclr; ce && command_register_wr && op == CMD_STOP_TIMER[4:0] && !timer_event
        |=> !arb_request[3]; endproperty
    a_tclr: assert property (p_tclr) else $error("timer flag not cleared");
    property p_aset; ce && addr_match_event |=> arb_request[5] || !interrupt_mask[5]; endproperty
    a_aset: assert property (p_aset) else $error("address flag not set");
    property p_aclr; ce && command_register_wr && op == CMD_RESET_ADDR_MATCH[4:0]
        && !addr_match_event |=> !arb_request[5]; endproperty
    a_aclr: assert property (p_aclr) else $error("address flag not cleared");
    // main scenarios reached
    c_armed: cover property (!interrupt_request_n);
    c_stop: cover property (ce && command_register_wr && op == CMD_STOP_TIMER[4:0]);
    c_read: cover property (reg_rd && reg_addr == STATUS_OFFSET);
endmodule // isr_monitor
bind uart_interrupt_status isr_monitor #(.CMD_STOP_TIMER(CMD_STOP_TIMER)) i_isr_monitor (
    .clk(clk), .rst_n(rst_n), .ce(ce), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_rdata(reg_rdata), .command_register_wr(command_register_wr),
    .command_register_code(command_register_code), .interrupt_mask(interrupt_mask),
    .global_chip_config0(global_chip_config0),
    .timer_event(timer_event), .addr_match_event(addr_match_event),
    .arb_request(arb_request), .interrupt_request_n(interrupt_request_n)
);

// *** test/host_model.sv ***
`timescale 1ns/1ns
module host_model (
    // clock and read port
    input wire logic clk,
    output logic reg_rd = 1'b0,
    output logic [7:0] reg_addr = 8'h00,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    // command register
    output logic command_register_wr = 1'b0,
    output logic [5:0] command_register_code = 6'h00
);
    // read: strobe taken at one edge, data taken while the answer stands
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a; // released address must not look valid
        @(negedge clk);
        d = reg_rvalid ? reg_rdata : 8'hxx;
    endtask
    // clearing commands are the host's duty
    task automatic cmd(input logic [5:0] c);
        @(posedge clk);
        command_register_wr <= 1'b1;
        command_register_code <= c;
        @(posedge clk);
        command_register_wr <= 1'b0;
        command_register_code <= ~c;
    endtask
endmodule // host_model

// *** test/uart_interrupt_status_tb.sv ***
`timescale 1ns/1ns
module uart_interrupt_status_tb;
    import isr_pkg::*;
    localparam logic [5:0] STOP = 6'h0c;
    localparam logic [5:0] BRK = 6'h05;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    // strobes: port rd, rxq rd, grxq rd, flow rd, load, addr, flow, timer, break, tick
    logic [9:0] stb = 10'h000;
    logic [7:0] mask = 8'hff;
    logic cfg = 1'b0;
    logic [1:0] pins = 2'b00;
    logic [8:0] rxl = 9'h000, txl = 9'h000;
    logic [7:0] m2 = 8'h00;
    logic [7:0] m0 = 8'h00;
    logic ce = 1'b1;
    logic [7:0] arb;
    logic rd, rv, wr, irq_n;
    logic [7:0] addr, rdata, d, st;
    logic [5:0] code;
    int errors = 0;
    int checks = 0;
    always #50 clk = ~clk;
    uart_interrupt_status #(.CMD_STOP_TIMER(STOP), .CMD_RESET_BREAK(BRK)) i_uart_interrupt_status (
        .clk(clk), .rst_n(rst_n), .ce(ce), .reg_rd(rd), .reg_addr(addr), .reg_rdata(rdata),
        .reg_rvalid(rv), .input_port_value_rd(stb[0]), .receive_queue_rd(stb[1]),
        .global_receive_queue_rd(stb[2]), .flow_char_status_rd(stb[3]),
        .command_register_wr(wr), .command_register_code(code), .interrupt_mask(mask),
        .global_chip_config0(cfg), .mode_reg_zero(m0), .mode_reg_two(m2),
        .input_pin_one(pins[1]), .input_pin_zero(pins[0]), .bit_tick(stb[9]),
        .rx_char_loaded(stb[4]), .addr_match_event(stb[5]), .flow_char_event(stb[6]),
        .timer_event(stb[7]), .break_change_event(stb[8]), .rx_level(rxl), .tx_level(txl),
        .arb_request(arb), .interrupt_request_n(irq_n));
    host_model i_host_model (.clk(clk), .reg_rd(rd), .reg_addr(addr), .reg_rdata(rdata),
        .reg_rvalid(rv), .command_register_wr(wr), .command_register_code(code));
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // interrupt request pin against the bench model
    task automatic cmp_irq(input logic got, input logic exp);
        cmp({7'h00, got}, {7'h00, exp});
    endtask
    // one-cycle strobe
    task automatic fire(input logic [9:0] v);
        @(posedge clk);
        stb <= v;
        @(posedge clk);
        stb <= 10'h000;
    endtask
    // status read against the bench model, raw or masked
    task automatic chk();
        i_host_model.rd(STATUS_OFFSET, d);
        cmp(d, cfg ? st & mask : st);
    endtask
    task automatic report_and_stop();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // hang guard, far beyond the few hundred cycles needed
    initial begin
        #2_000_000;
        errors++;
        report_and_stop();
    end
    initial begin
        void'($urandom(1648));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        st = 8'h01; // empty transmit queue only
        chk();
        for (int i = 0; i < 4; i++) begin
            fire(10'h020 << i);
            st[5 - i] = 1'b1;
            chk();
            chk();
        end
        cmp_irq(irq_n, 1'b0);
        i_host_model.cmd(CMD_RESET_ADDR_MATCH);
        st[5] = 1'b0;
        chk();
        fire(10'h008);
        st[4] = 1'b0;
        chk();
        i_host_model.cmd(STOP | 6'h20); // don't-care bit set
        st[3] = 1'b0;
        chk();
        i_host_model.cmd(BRK);
        st[2] = 1'b0;
        chk();
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            pins <= pins ^ (2'b01 << i);
            st[7] = 1'b1;
            chk();
            fire(10'h001);
            st[7] = 1'b0;
            chk();
        end
        // 64 idle bit times are not enough, the 65th sets the flag
        repeat (64) fire(10'h200);
        chk();
        fire(10'h200);
        st[6] = 1'b1;
        chk();
        fire(10'h002);
        st[6] = 1'b0;
        chk();
        repeat (60) fire(10'h200);
        fire(10'h010);
        repeat (10) fire(10'h200);
        chk();
        repeat (55) fire(10'h200);
        st[6] = 1'b1;
        chk();
        fire(10'h004);
        st[6] = 1'b0;
        chk();
        fire(10'h080);
        st[3] = 1'b1;
        repeat (6) begin
            @(posedge clk);
            mask <= 8'($urandom);
            cfg <= ~cfg;
            repeat (2) @(negedge clk);
            cmp_irq(irq_n, ~|(st & mask));
            cmp(arb, st & mask);
            chk();
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            m2 <= 8'(i << 2);
            rxl <= 9'(QUEUE_DEPTH / 2);
            st[1] = (i < 2);
            chk();
        end
        @(posedge clk);
        txl <= 9'h001;
        st[0] = 1'b0;
        chk();
        // every transmit trigger against a queue three eighths full
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            m0 <= 8'(i << 4);
            txl <= 9'(QUEUE_DEPTH * 3 / 8);
            st[0] = (i >= 2);
            chk();
        end
        // a frozen block must ignore a break event
        @(posedge clk);
        ce <= 1'b0;
        fire(10'h100);
        @(posedge clk);
        ce <= 1'b1;
        chk();
        fire(10'h100);
        st[2] = 1'b1;
        chk();
        report_and_stop();
    end
endmodule // uart_interrupt_status_tb
